// ==== hw/csf_pkg.sv ====
package csf_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned OC_TIME_MS     = 160;
    localparam int unsigned UV_TIME_MS     = 20;
    localparam int unsigned BLANK_TIME_MS  = 160;
    localparam int unsigned CLAMP_TIME_US  = 150;
    localparam int unsigned PWM_FREQ_HZ    = 120_000;
    localparam int unsigned SEQ_STEP_US    = 10;
    localparam int unsigned OC_CYCLES      = CLK_HZ / 1000 * OC_TIME_MS;
    localparam int unsigned UV_CYCLES      = CLK_HZ / 1000 * UV_TIME_MS;
    localparam int unsigned BLANK_CYCLES   = CLK_HZ / 1000 * BLANK_TIME_MS;
    localparam int unsigned CLAMP_CYCLES   = CLK_HZ / 1_000_000 * CLAMP_TIME_US;
    localparam int unsigned PWM_PERIOD     = CLK_HZ / PWM_FREQ_HZ;
    localparam int unsigned SEQ_STEP_CYC   = CLK_HZ / 1_000_000 * SEQ_STEP_US;

    // ****************************************************************
    // Configuration decode and reset values
    // ****************************************************************
    localparam logic [1:0] DIV_BY1       = 2'h0;
    localparam logic [1:0] DIV_BY2       = 2'h1;
    localparam logic [1:0] DIV_BY4       = 2'h2;
    localparam logic       VSEL_3V       = 1'h0;
    localparam logic       VSEL_5V       = 1'h1;
    localparam logic [3:0] CFG_RESET     = 4'h0;
    localparam logic [8:0] PIN_IDLE      = 9'h110;  // Select and ready/mode idle high, rest low
    localparam logic [3:0] DECODE_DEFAULT_VSEL = 4'h0;

    typedef struct packed {
        logic       vsel_5v;
        logic       sync_src;
        logic [1:0] div_sel;
    } csf_cfg_t;

    typedef struct packed {
        logic rst;
        logic aux;
        logic clk;
        logic dat;
        logic vcc;
    } csf_contacts_t;

endpackage

// ==== hw/csf_clkgen.sv ====
`timescale 1ns/1ns
// ********************************************************************
// Card clock divider, glitch-free for ratio changes between div 2 and div 4
// ********************************************************************
module csf_clkgen
(
    input  wire logic              ref_clk,    // System clock
    input  wire logic              reset_n,    // Async reset, active low
    input  wire logic              async_q,    // Qualified async clock level
    input  wire logic              sync_q,     // Qualified host sync clock level
    input  wire csf_pkg::csf_cfg_t cfg,        // Active configuration
    input  wire logic              enable,     // Clock contact enabled
    output logic                   card_clk_r  // Card clock level
);

    logic       async_d_r;
    logic [1:0] div_cnt_r;
    logic [1:0] act_div_r;
    logic       act_sync_r;
    logic       rise;

    // Count rising edges of the qualified async clock
    assign rise = async_q && !async_d_r;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            async_d_r <= 1'b0;
        else
            async_d_r <= async_q;
    end

    // Divider, sampled selection changes only while output low at a period boundary
    // so pulses keep full length when switching between div 2 and div 4; a switch to or from div 1 or sync can emit a pulse of neither length.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_cnt_r  <= 2'h0;
            card_clk_r <= 1'b0;
            act_div_r  <= csf_pkg::DIV_BY1;
            act_sync_r <= 1'b0;
        end
        else if (!enable)
        begin
            div_cnt_r  <= 2'h0;
            card_clk_r <= 1'b0;
            act_div_r  <= cfg.div_sel;
            act_sync_r <= cfg.sync_src;
        end
        else if (act_sync_r)
        begin
            card_clk_r <= sync_q;
            if (!sync_q && !cfg.sync_src)
            begin
                act_sync_r <= 1'b0;
                act_div_r  <= cfg.div_sel;
                div_cnt_r  <= 2'h0;
            end
        end
        else if (act_div_r == csf_pkg::DIV_BY1)
        begin
            card_clk_r <= async_q;
            if (!async_q && (cfg != {cfg.vsel_5v, act_sync_r, act_div_r}))
            begin
                act_sync_r <= cfg.sync_src;
                act_div_r  <= cfg.div_sel;
                div_cnt_r  <= 2'h0;
            end
        end
        else if (rise)
        begin
            // Half period is 1 (div 2) or 2 (div 4) input edges
            if (div_cnt_r == ((act_div_r == csf_pkg::DIV_BY4) ? 2'h1 : 2'h0))
            begin
                div_cnt_r  <= 2'h0;
                card_clk_r <= !card_clk_r;
                if (card_clk_r)
                begin
                    act_sync_r <= cfg.sync_src;
                    act_div_r  <= cfg.div_sel;
                end
            end
            else
                div_cnt_r <= div_cnt_r + 2'h1;
        end
    end

endmodule

// ==== hw/csf_top.sv ====
`timescale 1ns/1ns
module csf_top
#(
    parameter int unsigned OC_CYCLES    = csf_pkg::OC_CYCLES,     // Overcurrent span
    parameter int unsigned UV_CYCLES    = csf_pkg::UV_CYCLES,     // Undervoltage qualification
    parameter int unsigned BLANK_CYCLES = csf_pkg::BLANK_CYCLES,  // 3V to 5V blanking
    parameter int unsigned PWM_PERIOD   = csf_pkg::PWM_PERIOD,    // Switching period
    parameter int unsigned LIGHT_SKIP   = 15,                     // Max skipped cycles at light load
    parameter int unsigned SEQ_STEP     = csf_pkg::SEQ_STEP_CYC,  // Contact sequencing step
    parameter logic [31:0] DECODE_TABLE = 32'h4321_0000           // Eight 4-bit cfg entries
)
(
    input  wire logic             ref_clk,           // System clock, 50 MHz
    input  wire logic             reset_n,           // Async reset, active low
    input  wire logic             chip_select_n,     // Host chip select pin
    input  wire logic             power_on_request,  // Host power request pin
    input  wire logic             host_data_in,      // Host data pin level
    input  wire logic             host_reset_in,     // Host reset pin level
    input  wire logic             ready_mode_pin_in, // Ready/mode pin level
    input  wire logic             async_clock_in,    // Async clock pin
    input  wire logic             sync_clock_in,     // Host sync clock pin
    input  wire logic             peak_current_trip, // Peak current comparator
    input  wire logic             vcc_low,           // Card supply undervoltage comparator
    input  wire logic             vbat_ok,           // Battery monitor, adequate level
    input  wire logic             light_load,        // Regulation loop reports light load
    input  wire logic             card_extracted,    // Debounced extraction level
    output logic                  ready_mode_pin_out, // Ready/mode drive value
    output logic                  ready_mode_pin_oe, // Ready/mode output enable
    output logic                  low_side_on,       // Low-side switch gate
    output logic                  conv_enable,       // Converter running
    output logic                  vcc_pulldown,      // Card supply pull-down
    output logic                  vcc_clamp,         // Active clamp after extraction
    output logic                  vsel_5v,           // Supply selection, 5V high
    output logic                  card_reset_out,    // Card reset contact enable
    output logic                  card_aux_en,       // Aux contacts enable
    output logic                  card_clock_out,    // Card clock
    output logic                  card_data_en,      // Card data contact enable
    output logic                  clock_buffer_out,  // Buffered async clock
    output logic                  fault_r            // Fault latched
);

    // ****************************************************************
    // Pin qualification
    // ****************************************************************
    localparam int NIN = 9;
    logic [NIN-1:0] raw, s1_r, s2_r, s3_r, q_r;

    assign raw = {chip_select_n, power_on_request, host_data_in, host_reset_in,
                  ready_mode_pin_in, async_clock_in, sync_clock_in, card_extracted, vbat_ok};

    // Three stages; level accepted once stages two and three agree
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_r <= csf_pkg::PIN_IDLE;
            s2_r <= csf_pkg::PIN_IDLE;
            s3_r <= csf_pkg::PIN_IDLE;
            q_r  <= csf_pkg::PIN_IDLE;               // Idle levels, so no false edge follows reset
        end
        else
        begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < NIN; i++)
                if (s2_r[i] == s3_r[i])
                    q_r[i] <= s3_r[i];
        end
    end

    logic cs_n_q, pwr_q, data_q, hrst_q, rdy_q, aclk_q, sclk_q, extr_q, vbat_q;
    assign {cs_n_q, pwr_q, data_q, hrst_q, rdy_q, aclk_q, sclk_q, extr_q, vbat_q} = q_r;

    // ****************************************************************
    // Programming capture
    // ****************************************************************
    function automatic csf_pkg::csf_cfg_t decode(input logic [2:0] sel);
        decode = DECODE_TABLE[{sel, 2'b00} +: 4];
    endfunction

    logic              cs_d_r;
    logic              prog_arm_r;
    csf_pkg::csf_cfg_t cfg_r;
    logic              cs_rise;
    assign cs_rise = cs_n_q && !cs_d_r;

    // Programming window opens on select fall with ready/mode low
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cs_d_r     <= 1'b1;
            prog_arm_r <= 1'b0;
            cfg_r      <= csf_pkg::CFG_RESET;
        end
        else
        begin
            cs_d_r <= cs_n_q;
            if (!cs_n_q && cs_d_r)
                prog_arm_r <= !rdy_q;
            if (cs_rise && prog_arm_r && !rdy_q)
            begin
                cfg_r      <= decode({pwr_q, data_q, hrst_q});
                prog_arm_r <= 1'b0;
            end
        end
    end
    // Accepted whether converter runs or not
    assign vsel_5v = cfg_r.vsel_5v;

    // ****************************************************************
    // Supervision
    // ****************************************************************
    logic [31:0] oc_cnt_r, uv_cnt_r, blank_cnt_r;
    logic        vsel_d_r, uv_fault, oc_fault, run_req, host_stop;
    typedef enum {ST_OFF, ST_PWRUP, ST_ON, ST_PWRDN} st_t;
    st_t         st_r;
    logic [2:0]  step_r;
    logic [31:0] step_cnt_r;

    // Continuous trip integrator, any release restarts it
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            oc_cnt_r <= '0;
        else if (!conv_enable || !peak_current_trip)
            oc_cnt_r <= '0;
        else if (oc_cnt_r < OC_CYCLES)
            oc_cnt_r <= oc_cnt_r + 32'h1;
    end
    assign oc_fault = (oc_cnt_r >= OC_CYCLES);

    // Blanking after raising selection to 5V
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vsel_d_r    <= csf_pkg::VSEL_3V;
            blank_cnt_r <= '0;
        end
        else
        begin
            vsel_d_r <= cfg_r.vsel_5v;
            if (!vsel_d_r && cfg_r.vsel_5v)
                blank_cnt_r <= BLANK_CYCLES;
            else if (blank_cnt_r != 0)
                blank_cnt_r <= blank_cnt_r - 32'h1;
        end
    end

    // Undervoltage qualification, only counted once supply is up and not blanked
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            uv_cnt_r <= '0;
        else if (!vcc_low || st_r != ST_ON || blank_cnt_r != 0)
            uv_cnt_r <= '0;
        else if (uv_cnt_r < UV_CYCLES)
            uv_cnt_r <= uv_cnt_r + 32'h1;
    end
    assign uv_fault = (uv_cnt_r >= UV_CYCLES);

    // ****************************************************************
    // Power sequencer
    // ****************************************************************
    assign run_req   = pwr_q && !cs_n_q && !cs_d_r && !extr_q && !fault_r && !prog_arm_r;
    assign host_stop = !pwr_q && !cs_n_q && !cs_d_r && !prog_arm_r; // Request is a data bit while programming

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r        <= ST_OFF;
            step_r      <= 3'h0;
            step_cnt_r  <= '0;
            conv_enable <= 1'b0;
            fault_r     <= 1'b0;
        end
        else
        begin
            step_cnt_r <= (step_cnt_r != 0) ? step_cnt_r - 32'h1 : 32'h0;
            case (st_r)
                ST_OFF:
                begin
                    step_r <= 3'h0;
                    if (!pwr_q)
                        fault_r <= 1'b0;              // Released request clears old fault
                    if (run_req && vbat_q)
                    begin
                        conv_enable <= 1'b1;
                        st_r        <= ST_PWRUP;
                    end
                end
                ST_PWRUP:
                begin
                    if (extr_q || oc_fault || !pwr_q)
                        st_r <= ST_PWRDN;
                    else if (!vcc_low)
                    begin
                        st_r       <= ST_ON;
                        step_cnt_r <= SEQ_STEP;
                    end
                end
                ST_ON:
                begin
                    if (step_cnt_r == 0 && step_r != 3'h4)
                    begin
                        step_r     <= step_r + 3'h1;
                        step_cnt_r <= SEQ_STEP;
                    end
                    // Extraction wins over request level
                    if (extr_q || oc_fault || uv_fault || host_stop)
                    begin
                        fault_r    <= oc_fault || uv_fault || extr_q;
                        st_r       <= ST_PWRDN;
                        step_cnt_r <= SEQ_STEP;
                    end
                end
                ST_PWRDN:
                begin
                    if (oc_fault || uv_fault)
                        fault_r <= 1'b1;
                    // Contacts drop one by one; supply goes last
                    if (step_cnt_r == 0 || extr_q)
                    begin
                        step_cnt_r <= SEQ_STEP;
                        if (step_r != 3'h0)
                            step_r <= step_r - 3'h1;
                        else
                        begin
                            conv_enable <= 1'b0;
                            st_r        <= ST_OFF;
                        end
                    end
                end
                default:
                    st_r <= ST_OFF;
            endcase
        end
    end

    // Contact enables follow step: 1 data, 2 clock, 3 aux, 4 reset
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            card_data_en   <= 1'b0;
            card_aux_en    <= 1'b0;
            card_reset_out <= 1'b0;
            vcc_pulldown   <= 1'b1;
            vcc_clamp      <= 1'b0;
        end
        else
        begin
            card_data_en   <= step_r >= 3'h1;
            card_aux_en    <= step_r >= 3'h3;
            card_reset_out <= (step_r >= 3'h4) && hrst_q;
            vcc_pulldown   <= !conv_enable;
            vcc_clamp      <= extr_q;
        end
    end

    // Ready/mode: driven low for fault, high for ready, when selected outside programming
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ready_mode_pin_out <= 1'b0;
            ready_mode_pin_oe  <= 1'b0;
        end
        else
        begin
            ready_mode_pin_oe  <= !cs_n_q && !cs_d_r && !prog_arm_r; // Wait until programming entry is known
            ready_mode_pin_out <= !fault_r && !extr_q;
        end
    end

    // ****************************************************************
    // Switching oscillator
    // ****************************************************************
    logic [15:0] pwm_cnt_r;
    logic [3:0]  skip_r;
    logic        cyc_start;
    assign cyc_start = (pwm_cnt_r == 16'(PWM_PERIOD - 1));

    // Fixed period; light load skips cycles to lower frequency
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pwm_cnt_r   <= 16'h0;
            skip_r      <= 4'h0;
            low_side_on <= 1'b0;
        end
        else
        begin
            pwm_cnt_r <= cyc_start ? 16'h0 : pwm_cnt_r + 16'h1;
            if (!conv_enable)
                low_side_on <= 1'b0;
            else if (cyc_start)
            begin
                skip_r      <= (light_load && skip_r != 4'(LIGHT_SKIP)) ? skip_r + 4'h1 : 4'h0;
                low_side_on <= !(light_load && skip_r != 4'(LIGHT_SKIP)) && !peak_current_trip;
            end
            else if (peak_current_trip || pwm_cnt_r == 16'(PWM_PERIOD / 2))
                low_side_on <= 1'b0;
        end
    end

    // ****************************************************************
    // Card clock
    // ****************************************************************
    logic card_clk_w;

    csf_clkgen u_clkgen
    (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .async_q    (aclk_q),
        .sync_q     (sclk_q),
        .cfg        (cfg_r),
        .enable     (step_r >= 3'h2),
        .card_clk_r (card_clk_w)
    );

    // Buffer output retimed so it comes straight from a flip-flop
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clock_buffer_out <= 1'b0;
            card_clock_out   <= 1'b0;
        end
        else
        begin
            clock_buffer_out <= aclk_q;
            card_clock_out   <= card_clk_w;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    pwr_clamp_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(extr_q) |-> ##[1:2] vcc_clamp) else $error("clamp late");
    pull_down_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !conv_enable |=> vcc_pulldown) else $error("no pulldown");
    peak_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        peak_current_trip |=> !low_side_on) else $error("switch on during trip");
    start_bat_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(conv_enable) |-> $past(vbat_q)) else $error("start without battery");
    oc_stop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (st_r == ST_ON && oc_fault) |=> st_r == ST_PWRDN) else $error("overcurrent ignored");
    sequence data_last_s; !card_data_en ##1 !card_data_en; endsequence
    order_dn_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $fell(conv_enable) |-> (!card_aux_en && !card_reset_out) ##0 data_last_s) else $error("supply before contacts");
    cfg_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !cs_rise |=> $stable(cfg_r)) else $error("cfg changed off edge");
    blank_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (blank_cnt_r != 0) |=> uv_cnt_r == 0) else $error("uv during blank");

endmodule

// ==== verification/csf_card_model.sv ====
`timescale 1ns/1ns
// ****
// Card side: supply comparators, clock source
// ****
module csf_card_model
(
    input  wire logic ref_clk,      // System clock
    input  wire logic conv_on,      // Converter running
    input  wire logic short_i,      // Card overcurrent
    input  wire logic dip_i,        // Supply dip
    output logic      vcc_low,      // Undervoltage level
    output logic      trip,         // Peak current trip
    output logic      aclk = 1'b0   // Async clock
);
    logic [3:0] ramp_r = 4'h0;
    logic [2:0] div_r  = 3'h0;
    // Supply takes eight cycles to charge; clock period ten cycles
    always_ff @(posedge ref_clk)
    begin
        ramp_r <= conv_on ? ramp_r + {3'h0, ramp_r != 4'hF} : 4'h0;
        div_r  <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
        aclk   <= aclk ^ (div_r == 3'h4);
    end
    assign vcc_low = (ramp_r < 4'h8) || dip_i;
    assign trip    = short_i;
endmodule

// ==== verification/csf_top_test.sv ====
`timescale 1ns/1ns
// ****
// Bench
// ****
module csf_top_test;
    localparam int OC = 200;
    localparam int UV = 50;
    logic ref_clk, reset_n, chip_select_n, power_on_request, host_data_in, host_reset_in, sync_clock_in;
    logic vbat_ok, light_load, card_extracted, host_low, short_i, dip_i, peak_current_trip;
    logic ord_bad = 1'b0;
    logic ready_mode_pin_out, ready_mode_pin_oe, low_side_on, conv_enable, vcc_pulldown, vcc_clamp;
    logic vsel_5v, card_reset_out, card_aux_en, card_clock_out, card_data_en, clock_buffer_out, fault_r;
    logic vcc_low, async_clock_in;
    wire logic ready_mode_pin_in;
    int errors = 0;
    int cmp_count = 0;
    int n;
    // Pull-up unless host or device drives the pin
    assign ready_mode_pin_in = host_low ? 1'b0 : (ready_mode_pin_oe ? ready_mode_pin_out : 1'b1);
    csf_top #(.OC_CYCLES(OC), .UV_CYCLES(UV), .BLANK_CYCLES(200), .PWM_PERIOD(8), .SEQ_STEP(4),
        .DECODE_TABLE(32'h0491_0210)) csf_top_inst
    (.ref_clk, .reset_n, .chip_select_n, .power_on_request, .host_data_in, .host_reset_in, .ready_mode_pin_in,
     .async_clock_in, .sync_clock_in, .peak_current_trip, .vcc_low, .vbat_ok, .light_load, .card_extracted,
     .ready_mode_pin_out, .ready_mode_pin_oe, .low_side_on, .conv_enable, .vcc_pulldown, .vcc_clamp,
     .vsel_5v, .card_reset_out, .card_aux_en, .card_clock_out, .card_data_en, .clock_buffer_out, .fault_r);
    csf_card_model csf_card_model_inst
    (.ref_clk, .conv_on(conv_enable), .short_i, .dip_i, .vcc_low, .trip(peak_current_trip), .aclk(async_clock_in));
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Contacts must never be live out of order or without the converter
    always @(posedge ref_clk)
        if (reset_n && (card_reset_out && !card_aux_en || card_aux_en && !card_data_en
            || !conv_enable && (card_data_en || card_aux_en || card_reset_out)))
            ord_bad <= 1'b1;
    task cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask
    // Host sync clock, six system cycles a period, runs all the time
    initial
    begin
        sync_clock_in = 1'b0;
        forever
        begin
            cyc(3);
            sync_clock_in = ~sync_clock_in;
        end
    end
    task chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task wt(input int w, input logic v, input int lim, output int k);
        for (k = 0; k < lim; k++)
        begin
            if ((w == 0 ? conv_enable : w == 1 ? card_reset_out : vcc_clamp) === v)
                break;
            cyc(1);
        end
        if (k == lim)
        begin
            chk(1'b0, "wait timeout");
            summarize();
        end
    endtask
    // One full period of the card clock or the buffer, in system cycles
    task per(input logic b, input int e);
        int k, i;
        logic s, p;
        k = 0;
        p = 1'b1;
        for (i = 0; i < 400; i++)
        begin
            @(posedge ref_clk);
            s = b ? clock_buffer_out : card_clock_out;
            if (s && !p && k > 0)
                break;
            k = (s && !p) ? 1 : k + (k > 0);
            p = s;
        end
        #2;
        chk(k == e, "clock period");
        if (i == 400)
            summarize();
    endtask
    // Programming runs with the ready pin held low by the host
    task prog(input logic [2:0] idx, input logic v5);
        {chip_select_n, host_low} = 2'b11;
        cyc(8);
        chip_select_n = 1'b0;
        {power_on_request, host_data_in, host_reset_in} = idx;
        cyc(8);
        chip_select_n = 1'b1;
        cyc(8);
        host_low = 1'b0;
        chk(vsel_5v === v5, "supply selection");
    endtask
    task up();
        {chip_select_n, power_on_request, host_reset_in} = 3'b011;
        wt(1, 1'b1, 300, n);
    endtask
    initial
    begin
        {chip_select_n, power_on_request, host_data_in, host_reset_in} = 4'h8;
        {vbat_ok, light_load, card_extracted, host_low, short_i, dip_i} = 6'h00;
        reset_n = 1'b0;
        cyc(12);
        reset_n = 1'b1;
        cyc(6);
        chk(vcc_pulldown === 1'b1 && conv_enable === 1'b0, "idle supply");
        prog(3'h2, 1'b0);
        {chip_select_n, power_on_request} = 2'b01;
        cyc(40);
        chk(conv_enable === 1'b0, "start on low battery");
        vbat_ok = 1'b1;
        up();
        chk(vcc_pulldown === 1'b0, "pull-down when running");
        per(1'b0, 40);
        per(1'b1, 10);
        prog(3'h5, 1'b1);
        {chip_select_n, dip_i} = 2'b01;
        cyc(100);
        dip_i = 1'b0;
        chk(conv_enable === 1'b1, "fault during blanking");
        per(1'b0, 20);
        chk(conv_enable === 1'b1, "run after reprogram");
        prog(3'h6, 1'b0);
        chip_select_n = 1'b0;
        cyc(60);
        per(1'b0, 6);
        cyc(200);
        dip_i = 1'b1;
        cyc(UV / 2);
        dip_i = 1'b0;
        cyc(UV);
        chk(conv_enable === 1'b1, "brief dip");
        power_on_request = 1'b0;
        wt(0, 1'b0, 100, n);
        chk(fault_r === 1'b0, "host power-down");
        up();
        dip_i = 1'b1;
        wt(0, 1'b0, UV + 100, n);
        chk(n > UV - 5, "dip qualification");
        {dip_i, power_on_request} = 2'b00;
        cyc(50);
        up();
        short_i = 1'b1;
        cyc(3);
        chk(low_side_on === 1'b0, "switch off on trip");
        wt(0, 1'b0, OC + 100, n);
        chk(n > OC - 10, "overcurrent span");
        cyc(10);
        chk(ready_mode_pin_oe === 1'b1 && ready_mode_pin_out === 1'b0, "fault on ready pin");
        {short_i, power_on_request} = 2'b00;
        cyc(50);
        up();
        card_extracted = 1'b1;
        wt(2, 1'b1, 7500, n);
        wt(0, 1'b0, 200, n);
        chk(ord_bad === 1'b0, "contact order");
        summarize();
    end
endmodule
